// ### verilog/bds_pkg.sv
// Shared constants, types and helpers for both ends of the burst-of-two port
package bds_pkg;

	// Link widths
	localparam int ADDR_W = 8;
	localparam int DQ_W = 36;
	localparam int LANE_W = 9;
	localparam int LANES = 4;
	localparam int LANES_X18 = 2;
	localparam int WORDS = 256;

	// Byte mask value that writes no lane
	localparam logic [LANES-1:0] MASK_NONE_N = 4'hF;

	// Read pipeline in strobe half-edges: beat 0 leaves on the fourth
	// half-edge after the command, beat 1 on the fifth
	localparam int RD_PIPE = 5;
	localparam int RD_BEAT0_STG = 3;
	localparam int RD_BEAT1_STG = 4;

	// Host read-data buffer
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_AW = 4;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] BEATS_PER_BURST = 6'h02;
	localparam logic [CNT_W-1:0] FIFO_ROOM = 6'h10;

	// Write machine of the device end
	typedef enum logic [0:0] {
		BDS_WR_IDLE = 1'b0,
		BDS_WR_SECOND = 1'b1
	} bds_wr_state_t;

	// Second word of a burst: two-beat linear count
	function automatic logic [ADDR_W-1:0] burst_addr(
		input logic [ADDR_W-1:0] base, input logic beat);
		burst_addr = base + {{(ADDR_W-1){1'b0}}, beat};
	endfunction

	// Replace the lanes whose mask bit is low; x18 uses lanes 0 and 1 only
	function automatic logic [DQ_W-1:0] merge_lanes(
		input logic [DQ_W-1:0] old_w, input logic [DQ_W-1:0] new_w,
		input logic [LANES-1:0] mask_n, input logic x36);
		logic [DQ_W-1:0] res;
		res = old_w;
		for (int i = 0; i < LANES; i++) begin
			if (!mask_n[i] && (x36 || i < LANES_X18)) begin
				res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
			end
		end
		merge_lanes = res;
	endfunction

endpackage

// ### verilog/bds_link_if.sv
// Link between the memory controller end and the SRAM port end
`timescale 1ns/1ps
interface bds_link_if;
	import bds_pkg::*;

	logic strobe;
	logic rd_sel_n;
	logic wr_sel_n;
	logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0] wdata;
	logic [LANES-1:0] byte_write_mask_n;
	logic [DQ_W-1:0] rdata;
	logic rdata_oe_n;
	logic rdata_valid;

	modport dev (
		input strobe, rd_sel_n, wr_sel_n, addr, wdata, byte_write_mask_n,
		output rdata, rdata_oe_n, rdata_valid
	);

	modport host (
		output strobe, rd_sel_n, wr_sel_n, addr, wdata, byte_write_mask_n,
		input rdata, rdata_oe_n, rdata_valid
	);
endinterface

// ### verilog/bds_dev_port.sv
// SRAM port end: read and write machines, write buffer and memory array
`timescale 1ns/1ps
// Function
// - Second burst word is base address plus one
// - Read select low at primary edge reads
// - Write select low at primary edge writes
// - Read and write machines run independently
// - Commands taken on primary rising edge; machines step on both strobe edges
// - Controller finishes transfers before stopping strobe
// - Same command on next primary edge dropped
// - Both selects after idle: read, drop write
// - Masked write needs write select at t
// - x18 masks gate lanes 0-8 and 9-17
// - x36 masks gate four nine-bit lanes
// - Reads of buffered address return buffer data
// - No write select leaves array untouched
module bds_dev_port
	import bds_pkg::*;
#(
	parameter bit ORG_X36 = 1'b1
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Link
	bds_link_if.dev link,
	// Status
	output logic rd_busy_o,
	output logic wr_busy_o,
	output logic wbuf_valid_o
);

	// Strobe edge detection
	logic strobe_prev_q;
	logic k_rise;
	logic k_fall;
	logic any_edge;

	// Command acceptance
	logic prev_rd_q, prev_rd_d;
	logic prev_wr_q, prev_wr_d;
	logic prev_nop_q, prev_nop_d;
	logic rd_go;
	logic wr_go;

	// Read pipeline
	logic [RD_PIPE-1:0] rd_v_q, rd_v_d;
	logic [ADDR_W-1:0] rd_a_q [RD_PIPE];
	logic [ADDR_W-1:0] rd_a_d [RD_PIPE];
	logic [DQ_W-1:0] dq_q, dq_d;
	logic oe_n_q, oe_n_d;

	// Write machine and write buffer
	bds_wr_state_t wr_st_q, wr_st_d;
	logic [DQ_W-1:0] wr_d0_q, wr_d0_d;
	logic [LANES-1:0] wr_m0_q, wr_m0_d;
	logic wb_v_q, wb_v_d;
	logic [ADDR_W-1:0] wb_addr_q, wb_addr_d;
	logic [DQ_W-1:0] wb_d0_q, wb_d0_d, wb_d1_q, wb_d1_d;
	logic [LANES-1:0] wb_m0_q, wb_m0_d, wb_m1_q, wb_m1_d;
	logic commit;

	// Memory array
	logic [DQ_W-1:0] mem_q [WORDS];

	// Word as seen by a read: array contents overlaid by the write buffer
	function automatic logic [DQ_W-1:0] read_word(input logic [ADDR_W-1:0] a);
		logic [DQ_W-1:0] w;
		w = mem_q[a];
		if (wb_v_q && burst_addr(wb_addr_q, 1'b0) == a) begin
			w = merge_lanes(w, wb_d0_q, wb_m0_q, ORG_X36);
		end
		if (wb_v_q && burst_addr(wb_addr_q, 1'b1) == a) begin
			w = merge_lanes(w, wb_d1_q, wb_m1_q, ORG_X36);
		end
		read_word = w;
	endfunction

	// Edges of the strobe; nothing moves between them
	assign k_rise = link.strobe & ~strobe_prev_q;
	assign k_fall = ~link.strobe & strobe_prev_q;
	assign any_edge = k_rise | k_fall;

	// Command decode with spacing and collision handling
	assign rd_go = k_rise & ~link.rd_sel_n & ~prev_rd_q;
	assign wr_go = k_rise & ~link.wr_sel_n & ~prev_wr_q
		& ~(~link.rd_sel_n & prev_nop_q);

	// History of the previous primary edge
	always_comb begin
		prev_rd_d = prev_rd_q;
		prev_wr_d = prev_wr_q;
		prev_nop_d = prev_nop_q;
		if (k_rise) begin
			prev_rd_d = rd_go;
			prev_wr_d = wr_go;
			prev_nop_d = link.rd_sel_n & link.wr_sel_n;
		end
	end

	// Read machine: half-edge pipeline of addresses and output beats
	always_comb begin
		rd_v_d = rd_v_q;
		rd_a_d = rd_a_q;
		dq_d = dq_q;
		oe_n_d = oe_n_q;
		if (any_edge) begin
			rd_v_d = {rd_v_q[RD_PIPE-2:0], rd_go};
			rd_a_d[0] = link.addr;
			for (int i = 1; i < RD_PIPE; i++) begin
				rd_a_d[i] = rd_a_q[i-1];
			end
			if (rd_v_q[RD_BEAT0_STG]) begin
				dq_d = read_word(rd_a_q[RD_BEAT0_STG]);
				oe_n_d = 1'b0;
			end else if (rd_v_q[RD_BEAT1_STG]) begin
				dq_d = read_word(burst_addr(rd_a_q[RD_BEAT1_STG], 1'b1));
				oe_n_d = 1'b0;
			end else begin
				oe_n_d = 1'b1;
			end
		end
	end

	// Write machine: beat 0 at primary edge, address and beat 1 at inverted
	always_comb begin
		wr_st_d = wr_st_q;
		wr_d0_d = wr_d0_q;
		wr_m0_d = wr_m0_q;
		wb_v_d = wb_v_q;
		wb_addr_d = wb_addr_q;
		wb_d0_d = wb_d0_q;
		wb_d1_d = wb_d1_q;
		wb_m0_d = wb_m0_q;
		wb_m1_d = wb_m1_q;
		commit = 1'b0;
		unique case (wr_st_q)
			BDS_WR_IDLE: begin
				if (wr_go) begin
					wr_st_d = BDS_WR_SECOND;
					wr_d0_d = link.wdata;
					wr_m0_d = link.byte_write_mask_n;
				end
			end
			BDS_WR_SECOND: begin
				if (k_fall) begin
					// Older buffered burst goes to the array
					commit = wb_v_q;
					wr_st_d = BDS_WR_IDLE;
					wb_v_d = 1'b1;
					wb_addr_d = link.addr;
					wb_d0_d = wr_d0_q;
					wb_m0_d = wr_m0_q;
					wb_d1_d = link.wdata;
					wb_m1_d = link.byte_write_mask_n;
				end
			end
		endcase
	end

	// Registers of all machines
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			strobe_prev_q <= 1'b0;
			prev_rd_q <= 1'b0;
			prev_wr_q <= 1'b0;
			prev_nop_q <= 1'b1;
			rd_v_q <= '0;
			for (int i = 0; i < RD_PIPE; i++) begin
				rd_a_q[i] <= '0;
			end
			dq_q <= '0;
			oe_n_q <= 1'b1;
			wr_st_q <= BDS_WR_IDLE;
			wr_d0_q <= '0;
			wr_m0_q <= MASK_NONE_N;
			wb_v_q <= 1'b0;
			wb_addr_q <= '0;
			wb_d0_q <= '0;
			wb_d1_q <= '0;
			wb_m0_q <= MASK_NONE_N;
			wb_m1_q <= MASK_NONE_N;
		end else begin
			strobe_prev_q <= link.strobe;
			prev_rd_q <= prev_rd_d;
			prev_wr_q <= prev_wr_d;
			prev_nop_q <= prev_nop_d;
			rd_v_q <= rd_v_d;
			rd_a_q <= rd_a_d;
			dq_q <= dq_d;
			oe_n_q <= oe_n_d;
			wr_st_q <= wr_st_d;
			wr_d0_q <= wr_d0_d;
			wr_m0_q <= wr_m0_d;
			wb_v_q <= wb_v_d;
			wb_addr_q <= wb_addr_d;
			wb_d0_q <= wb_d0_d;
			wb_d1_q <= wb_d1_d;
			wb_m0_q <= wb_m0_d;
			wb_m1_q <= wb_m1_d;
		end
	end

	// Array update only from a buffered write burst; lanes gated per beat
	always_ff @(posedge ref_clk_i) begin
		if (commit) begin
			mem_q[burst_addr(wb_addr_q, 1'b0)] <= merge_lanes(
				mem_q[burst_addr(wb_addr_q, 1'b0)], wb_d0_q, wb_m0_q, ORG_X36);
			mem_q[burst_addr(wb_addr_q, 1'b1)] <= merge_lanes(
				mem_q[burst_addr(wb_addr_q, 1'b1)], wb_d1_q, wb_m1_q, ORG_X36);
		end
	end

	// Link outputs
	assign link.rdata = dq_q;
	assign link.rdata_oe_n = oe_n_q;
	assign link.rdata_valid = ~oe_n_q;

	// Status outputs
	assign rd_busy_o = |rd_v_q;
	assign wr_busy_o = (wr_st_q == BDS_WR_SECOND);
	assign wbuf_valid_o = wb_v_q;

endmodule

// ### verilog/bds_host_ctrl.sv
// Controller end: strobe generation, command issue and read-data FIFO
`timescale 1ns/1ps
module bds_fifo
	import bds_pkg::*;
#(
	parameter int W = DQ_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o,
	// Fill level
	output logic [$clog2(DEPTH):0] level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0] wp_q, wp_d, rp_q, rp_d;
	logic push, pop;

	// Pointers carry one wrap bit for honest full and empty
	assign level_o = wp_q - rp_q;
	assign in_ready_o = (level_o != DEPTH[AW:0]);
	assign out_valid_o = (wp_q != rp_q);
	assign out_data_o = mem_q[rp_q[AW-1:0]];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	// Next pointers
	always_comb begin
		wp_d = push ? wp_q + 1'b1 : wp_q;
		rp_d = pop ? rp_q + 1'b1 : rp_q;
	end

	// Pointer registers
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
		end
	end

	// Storage
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_q[wp_q[AW-1:0]] <= in_data_i;
		end
	end
endmodule

module bds_host_ctrl
	import bds_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Link
	bds_link_if.host link,
	// Command request
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire logic cmd_write_i,
	input wire logic [ADDR_W-1:0] cmd_addr_i,
	input wire logic [DQ_W-1:0] cmd_wdata0_i,
	input wire logic [DQ_W-1:0] cmd_wdata1_i,
	input wire logic [LANES-1:0] cmd_mask0_n_i,
	input wire logic [LANES-1:0] cmd_mask1_n_i,
	// Strobe run request and status
	input wire logic run_i,
	output logic busy_o,
	// Read data
	output logic rd_valid_o,
	input wire logic rd_ready_i,
	output logic [DQ_W-1:0] rd_data_o
);

	logic str_q, str_d, str1_q, str2_q;
	logic rsel_n_q, rsel_n_d, wsel_n_q, wsel_n_d;
	logic [ADDR_W-1:0] addr_q, addr_d, haddr_q, haddr_d;
	logic [DQ_W-1:0] wd_q, wd_d, hdata_q, hdata_d;
	logic [LANES-1:0] mk_q, mk_d, hmask_q, hmask_d;
	logic wr_half_q, wr_half_d;
	logic last_rd_q, last_rd_d, last_wr_q, last_wr_d;
	logic [CNT_W-1:0] pend_q, pend_d;
	logic [FIFO_AW:0] fifo_lvl;
	logic fifo_in_ready;
	logic go, spaced, room, take, push;

	// Strobe keeps running until every outstanding beat is done
	assign go = run_i | (pend_q != '0) | wr_half_q | str_q;
	assign spaced = cmd_write_i ? ~last_wr_q : ~last_rd_q;
	assign room = cmd_write_i | (fifo_in_ready &&
		({1'b0, fifo_lvl} + pend_q + BEATS_PER_BURST <= FIFO_ROOM));
	assign cmd_ready_o = ~str_q & go & spaced & room;
	assign take = cmd_valid_i & cmd_ready_o;
	// Device output changes one cycle after the edge it saw
	assign push = link.rdata_valid & ~link.rdata_oe_n & (str1_q ^ str2_q);
	assign busy_o = go & ~run_i;

	// Next link drive: commands at primary edge, write beat 1 at inverted
	always_comb begin
		str_d = str_q;
		rsel_n_d = rsel_n_q;
		wsel_n_d = wsel_n_q;
		addr_d = addr_q;
		wd_d = wd_q;
		mk_d = mk_q;
		haddr_d = haddr_q;
		hdata_d = hdata_q;
		hmask_d = hmask_q;
		wr_half_d = wr_half_q;
		last_rd_d = last_rd_q;
		last_wr_d = last_wr_q;
		pend_d = pend_q - {{(CNT_W-1){1'b0}}, push};
		if (go && !str_q) begin
			str_d = 1'b1;
			rsel_n_d = ~(take & ~cmd_write_i);
			wsel_n_d = ~(take & cmd_write_i);
			addr_d = cmd_addr_i;
			wd_d = cmd_wdata0_i;
			mk_d = (take & cmd_write_i) ? cmd_mask0_n_i : MASK_NONE_N;
			haddr_d = cmd_addr_i;
			hdata_d = cmd_wdata1_i;
			hmask_d = cmd_mask1_n_i;
			wr_half_d = take & cmd_write_i;
			last_rd_d = take & ~cmd_write_i;
			last_wr_d = take & cmd_write_i;
			if (take && !cmd_write_i) begin
				pend_d = pend_q + BEATS_PER_BURST - {{(CNT_W-1){1'b0}}, push};
			end
		end else if (str_q) begin
			str_d = 1'b0;
			rsel_n_d = 1'b1;
			wsel_n_d = 1'b1;
			addr_d = haddr_q;
			wd_d = hdata_q;
			mk_d = wr_half_q ? hmask_q : MASK_NONE_N;
			wr_half_d = 1'b0;
		end
	end

	// Registers of the controller end
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			str_q <= 1'b0;
			str1_q <= 1'b0;
			str2_q <= 1'b0;
			rsel_n_q <= 1'b1;
			wsel_n_q <= 1'b1;
			addr_q <= '0;
			wd_q <= '0;
			mk_q <= MASK_NONE_N;
			haddr_q <= '0;
			hdata_q <= '0;
			hmask_q <= MASK_NONE_N;
			wr_half_q <= 1'b0;
			last_rd_q <= 1'b0;
			last_wr_q <= 1'b0;
			pend_q <= '0;
		end else begin
			str_q <= str_d;
			str1_q <= str_q;
			str2_q <= str1_q;
			rsel_n_q <= rsel_n_d;
			wsel_n_q <= wsel_n_d;
			addr_q <= addr_d;
			wd_q <= wd_d;
			mk_q <= mk_d;
			haddr_q <= haddr_d;
			hdata_q <= hdata_d;
			hmask_q <= hmask_d;
			wr_half_q <= wr_half_d;
			last_rd_q <= last_rd_d;
			last_wr_q <= last_wr_d;
			pend_q <= pend_d;
		end
	end

	// Link drive
	assign link.strobe = str_q;
	assign link.rd_sel_n = rsel_n_q;
	assign link.wr_sel_n = wsel_n_q;
	assign link.addr = addr_q;
	assign link.wdata = wd_q;
	assign link.byte_write_mask_n = mk_q;

	// Read beats are buffered; issue of reads stalls when room runs out
	bds_fifo #(
		.W(DQ_W),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(link.rdata),
		.out_valid_o(rd_valid_o),
		.out_ready_i(rd_ready_i),
		.out_data_o(rd_data_o),
		.level_o(fifo_lvl)
	);

endmodule

// ### dv/bds_chk.sv
// Link protocol checker for the burst-of-two port
`timescale 1ns/1ps
module bds_chk
	import bds_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// Link signals
	input wire logic strobe,
	input wire logic rd_sel_n,
	input wire logic wr_sel_n,
	input wire logic [DQ_W-1:0] rdata,
	input wire logic rdata_oe_n,
	input wire logic rdata_valid
);
	logic rd_req;

	// Read request level as the device samples it
	assign rd_req = strobe && !rd_sel_n;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Commands at the primary edge, output beats and a stopped strobe
	sequence s_rd;
		$rose(strobe) && !rd_sel_n;
	endsequence
	sequence s_wr;
		$rose(strobe) && !wr_sel_n;
	endsequence
	sequence s_beats;
		!rdata_oe_n [*2] ##1 rdata_oe_n;
	endsequence
	sequence s_stop;
		!strobe [*2];
	endsequence

	property p_rd_lat; s_rd |-> ##5 s_beats; endproperty
	property p_oe_cause; $fell(rdata_oe_n) |-> $past(rd_req, 5); endproperty
	property p_valid; rdata_valid == !rdata_oe_n; endproperty
	property p_sel_edge; !rd_sel_n || !wr_sel_n |-> $rose(strobe); endproperty
	property p_rd_gap; s_rd |-> ##2 rd_sel_n; endproperty
	property p_wr_gap; s_wr |-> ##2 wr_sel_n; endproperty
	property p_wr_beat; s_wr |=> $fell(strobe) && wr_sel_n; endproperty
	property p_one_cmd; !(!rd_sel_n && !wr_sel_n); endproperty
	property p_hold; s_stop |=> $stable(rdata_oe_n) && $stable(rdata);
	endproperty

	a_rd_lat: assert property (p_rd_lat)
		else $error("read beats off time");
	a_oe_cause: assert property (p_oe_cause)
		else $error("read port driven without a read");
	a_valid: assert property (p_valid)
		else $error("valid flag disagrees with drive");
	a_sel_edge: assert property (p_sel_edge)
		else $error("select outside a primary edge");
	a_rd_gap: assert property (p_rd_gap)
		else $error("reads on adjacent primary edges");
	a_wr_gap: assert property (p_wr_gap)
		else $error("writes on adjacent primary edges");
	a_wr_beat: assert property (p_wr_beat)
		else $error("second write beat misplaced");
	a_one_cmd: assert property (p_one_cmd)
		else $error("read and write selected together");
	a_hold: assert property (p_hold)
		else $error("read port moved with strobe stopped");
endmodule

// ### dv/burst2_ddr_sram_port_logic_bench.sv
// Bench joining the controller end to the SRAM port end
`timescale 1ns/1ps
module burst2_ddr_sram_port_logic_bench;
	import bds_pkg::*;
	logic ref_clk_i, rst_n_i, cmd_valid_i, cmd_ready_o, cmd_write_i;
	logic run_i, busy_o, rd_valid_o, rd_ready_i;
	logic [ADDR_W-1:0] cmd_addr_i;
	logic [DQ_W-1:0] cmd_wdata0_i, cmd_wdata1_i, rd_data_o;
	logic [LANES-1:0] cmd_mask0_n_i, cmd_mask1_n_i;
	logic rd_valid_x18;
	logic [DQ_W-1:0] rd_data_x18;
	logic [DQ_W-1:0] mem [WORDS];
	logic [DQ_W-1:0] exp_q [$];
	int error_cnt = 0;
	int compares = 0;
	bit stall = 1'b0;
	bit took;

	// Both ends across one link, checker beside it
	bds_link_if link();
	bds_dev_port #(.ORG_X36(1'b1)) bds_dev_port_i (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .link(link), .rd_busy_o(), .wr_busy_o(),
		.wbuf_valid_o());
	bds_host_ctrl bds_host_ctrl_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.link(link), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
		.cmd_write_i(cmd_write_i), .cmd_addr_i(cmd_addr_i),
		.cmd_wdata0_i(cmd_wdata0_i), .cmd_wdata1_i(cmd_wdata1_i),
		.cmd_mask0_n_i(cmd_mask0_n_i), .cmd_mask1_n_i(cmd_mask1_n_i),
		.run_i(run_i), .busy_o(busy_o), .rd_valid_o(rd_valid_o),
		.rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o));
	// Narrow organisation runs in lockstep on the same commands
	bds_link_if link_x18();
	bds_dev_port #(.ORG_X36(1'b0)) bds_dev_port_x18_i (
		.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link_x18),
		.rd_busy_o(), .wr_busy_o(), .wbuf_valid_o());
	bds_host_ctrl bds_host_ctrl_x18_i (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .link(link_x18), .cmd_valid_i(cmd_valid_i),
		.cmd_ready_o(), .cmd_write_i(cmd_write_i),
		.cmd_addr_i(cmd_addr_i), .cmd_wdata0_i(cmd_wdata0_i),
		.cmd_wdata1_i(cmd_wdata1_i), .cmd_mask0_n_i(cmd_mask0_n_i),
		.cmd_mask1_n_i(cmd_mask1_n_i), .run_i(run_i), .busy_o(),
		.rd_valid_o(rd_valid_x18), .rd_ready_i(rd_ready_i),
		.rd_data_o(rd_data_x18));
	bds_chk bds_chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.strobe(link.strobe), .rd_sel_n(link.rd_sel_n),
		.wr_sel_n(link.wr_sel_n), .rdata(link.rdata),
		.rdata_oe_n(link.rdata_oe_n), .rdata_valid(link.rdata_valid));

	// 40 MHz reference clock
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end

	// Count a comparison and report a mismatch
	task automatic chk(string name, logic [DQ_W-1:0] exp,
		logic [DQ_W-1:0] got);
		compares++;
		if (got !== exp || $isunknown(exp)) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Print the counts and the verdict, then stop
	task automatic end_of_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Expected image: only lanes with a low mask bit change
	function automatic void put(logic [7:0] a, logic [DQ_W-1:0] d,
		logic [3:0] m);
		for (int i = 0; i < LANES; i++) begin
			if (!m[i]) begin
				mem[a][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
			end
		end
	endfunction

	// Offer one burst command; note the data it must produce
	task automatic cmd(bit w, logic [7:0] a, logic [3:0] m0 = 4'h0,
		logic [3:0] m1 = 4'h0, int lim = 200, bit may_refuse = 1'b0);
		int n;
		logic [DQ_W-1:0] d0, d1;
		n = 0;
		d0 = DQ_W'({$urandom(), $urandom()});
		d1 = DQ_W'({$urandom(), $urandom()});
		cmd_valid_i = 1'b1;
		cmd_write_i = w;
		cmd_addr_i = a;
		cmd_wdata0_i = d0;
		cmd_wdata1_i = d1;
		cmd_mask0_n_i = m0;
		cmd_mask1_n_i = m1;
		while (!cmd_ready_o && n < lim) begin
			@(posedge ref_clk_i) #2;
			n++;
		end
		took = cmd_ready_o;
		if (!took) begin
			if (!may_refuse) begin
				error_cnt++;
			end
			return;
		end
		@(posedge ref_clk_i) #2;
		if (w) begin
			put(a, d0, m0);
			put(a + 8'h01, d1, m1);
		end else begin
			exp_q.push_back(mem[a]);
			exp_q.push_back(mem[a + 8'h01]);
		end
	endtask

	// Stop the strobe once work is done; the read port must stay quiet
	task automatic pause();
		int n;
		n = 0;
		cmd_valid_i = 1'b0;
		run_i = 1'b0;
		do begin
			@(posedge ref_clk_i) #2;
			n++;
		end while (busy_o && n < 50);
		chk("busy_o", DQ_W'(0), DQ_W'(busy_o));
		repeat (6) @(posedge ref_clk_i);
		#2 chk("oe_n", DQ_W'(1), DQ_W'(link.rdata_oe_n));
		run_i = 1'b1;
	endtask

	// Drain side accepts at random unless stalled
	always @(posedge ref_clk_i) begin
		#2 rd_ready_i = !stall && ($urandom_range(3) != 0);
	end

	// Each word leaving the buffer is matched to the oldest note
	always @(posedge ref_clk_i) begin
		logic [DQ_W-1:0] e, lo;
		if (rst_n_i && rd_valid_o && rd_ready_i) begin
			e = exp_q.size() ? exp_q.pop_front() : 'x;
			chk("rd_data", e, rd_data_o);
			lo = DQ_W'({rd_valid_x18, rd_data_x18[2*LANE_W-1:0]});
			chk("rd_x18", DQ_W'({1'b1, e[2*LANE_W-1:0]}), lo);
		end
	end

	// Watchdog
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		error_cnt++;
		end_of_test();
	end

	initial begin
		logic [7:0] a;
		int acc;
		rst_n_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_write_i = 1'b0;
		cmd_addr_i = '0;
		cmd_wdata0_i = '0;
		cmd_wdata1_i = '0;
		cmd_mask0_n_i = 4'hF;
		cmd_mask1_n_i = 4'hF;
		run_i = 1'b0;
		void'($urandom(32'h9D51B1F0));
		repeat (8) @(posedge ref_clk_i);
		#2 rst_n_i = 1'b1;
		run_i = 1'b1;
		// Seed the burst that the first older-burst read returns
		cmd(1'b1, 8'hA2);
		// Full write, masked rewrite, read back, read the older burst
		for (int k = 1; k <= 32; k++) begin
			a = 8'(3 * k) + 8'hA2;
			cmd(1'b1, a);
			cmd(1'b1, a, 4'(k), ~4'(k));
			cmd(1'b0, a);
			cmd(1'b0, a - 8'h03);
			if (k % 8 == 0) begin
				pause();
			end
		end
		// Fill the read buffer with the drain side stalled
		while (exp_q.size() != 0) @(posedge ref_clk_i);
		@(posedge ref_clk_i);
		stall = 1'b1;
		#2 acc = 0;
		for (int i = 0; i < 12; i++) begin
			cmd(1'b0, 8'hA5 + 8'(3 * i), 4'h0, 4'h0, 12, 1'b1);
			acc += took;
		end
		cmd_valid_i = 1'b0;
		chk("reads_held", DQ_W'(FIFO_DEPTH / 2), DQ_W'(acc));
		// Drain until empty
		@(posedge ref_clk_i);
		stall = 1'b0;
		while (exp_q.size() != 0) @(posedge ref_clk_i);
		#2 chk("drained", '0, DQ_W'(rd_valid_o));
		pause();
		end_of_test();
	end
endmodule
